// ### design/signaling_extractor_pkg.sv
// constants for the receive signaling extractor with indirect access engine
// assumes a 125 MHz system clock and a wishbone master with 32-bit data
package signaling_extractor_pkg;

    // clock and access timing
    localparam int CLK_MHZ        = 125;
    localparam int ACCESS_TIME_NS = 640;
    localparam int ACCESS_CYCLES  = (ACCESS_TIME_NS * CLK_MHZ) / 1000;
    localparam int ACCESS_CNT_W   = 7;

    // register indices; byte address is four times the index
    localparam int          ADR_W         = 10;
    localparam int          ADR_LSB       = 2;
    localparam logic [7:0] REG_CONFIG     = 8'h40;
    localparam logic [7:0] REG_STATUS     = 8'h41;
    localparam logic [7:0] REG_ADDR_CTRL  = 8'h42;
    localparam logic [7:0] REG_DATA_BUF   = 8'h43;

    // extractor configuration fields
    localparam int         CFG_W          = 5;
    localparam int         CFG_ESF_BIT    = 4;
    localparam int         CFG_FMS_HI_BIT = 3;
    localparam int         CFG_FMS_LO_BIT = 2;
    localparam int         CFG_IA_BIT     = 1;
    localparam int         CFG_PCH_BIT    = 0;
    localparam logic [4:0] CFG_RESET      = 5'h00;

    // status, address/control and data buffer fields
    localparam int         STATUS_BUSY_BIT = 7;
    localparam int         DIR_BIT         = 7;
    localparam int         IADDR_W         = 6;
    localparam int         SPACE_BIT       = 5;
    localparam int         NIBBLE_W        = 4;
    localparam logic [5:0] IADDR_RESET     = 6'h00;
    localparam logic [3:0] NIBBLE_RESET    = 4'h0;

    // internal address map
    localparam int         CHAN_COUNT   = 24;
    localparam logic [5:0] SIG_FIRST    = 6'h01;
    localparam logic [5:0] SIG_LAST     = 6'h18;
    localparam logic [5:0] EXT_CFG_ADDR = 6'h20;
    localparam logic [5:0] CCFG_FIRST   = 6'h21;
    localparam logic [5:0] CCFG_LAST    = 6'h38;

    // per-channel configuration fields
    localparam int CC_FLP_BIT = 3;
    localparam int CC_FIX_BIT = 2;
    localparam int CC_LVL_BIT = 1;
    localparam int CC_DBN_BIT = 0;

    // superframe structure: frames count from 1, channels from 0
    localparam logic [4:0] FRAME_A    = 5'd6;
    localparam logic [4:0] FRAME_B    = 5'd12;
    localparam logic [4:0] FRAME_C    = 5'd18;
    localparam logic [4:0] FRAME_D    = 5'd24;
    localparam logic [4:0] LAST_CHAN  = 5'd23;
    localparam int         BIT_A      = 3;
    localparam int         BIT_B      = 2;
    localparam int         BIT_C      = 1;
    localparam int         BIT_D      = 0;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_WAIT = 3'b010,
        ENG_DONE = 3'b100
    } engine_state_type;

endpackage

// ### design/signaling_extractor.sv
// receive signaling extractor: wishbone register bank, indirect access engine,
// per-channel signaling history with debounce and per-channel pcm processing.
// assumes the pcm stream comes from framer logic on clk_i (no synchroniser)
// Overview of operation
// R1: extended superframe bit set selects extended superframe and ignores both mode bits
// R2: otherwise mode bit hi 0 selects standard superframe, 1 the alternate carrier format
// R3: mode bit lo 1 stops extraction, zeroes signaling stream, disables bit fixing
// R4: host must set indirect access enable before using the extractor
// R5: per-channel enable applies inversion, fixing and debounce; cleared disables them all
// R6: reset clears format, mode, indirect enable and per-channel enable bits
// R7: busy reads 1 during an indirect access and falls after it completes
// R8: host polls busy until 0 before starting another indirect access
// R9: an indirect access finishes within 640 ns
// R10: writing address/control with a valid address launches one indirect access
// R11: address/control holds internal address in bits 5:0, direction in bit 7
// R12: host loads the data buffer before launching an indirect write
// R13: indirect read places the nibble in data buffer bits 3:0 within 640 ns
// R14: internal address bit 5 selects configuration space, else signaling data
// R15: addresses 01H upward are channel signaling data, one per channel
// R16: 20H is extractor configuration, 21H upward channel configuration, 19H-1FH ignored
// R17: signaling read returns A,B,C,D in bits 3..0, upper bits zero
// R18: in the superframe formats C reads as A and D reads as B
// R19: returned signaling is from the third to last superframe received
// R20: with debounce, a new state shows only after two equal superframes
// R21: channel configuration holds invert, fix, force level and debounce bits 3..0
// R22: fixing forces the byte lsb to force level, inverted when inversion is on
`timescale 1ns/10ps
module signaling_extractor (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // receive pcm stream from the framer
    input  wire logic        pcm_valid_i,
    input  wire logic        pcm_fbit_i,
    input  wire logic [4:0]  pcm_chan_i,
    input  wire logic [4:0]  pcm_frame_i,
    input  wire logic [7:0]  pcm_data_i,
    // processed pcm and signaling stream
    output logic             pcm_valid_o,
    output logic      [7:0]  pcm_data_o,
    output logic             sig_stream_o
);

    // register file
    logic [signaling_extractor_pkg::CFG_W-1:0]    config_reg;
    logic                                         busy_reg;
    logic                                         direction_reg;
    logic [signaling_extractor_pkg::IADDR_W-1:0]  iaddr_reg;
    logic [signaling_extractor_pkg::NIBBLE_W-1:0] nibble_reg;
    logic [31:0]                                  dat_reg;
    logic                                         ack_reg;

    // indirect engine
    signaling_extractor_pkg::engine_state_type           eng_reg;
    logic [signaling_extractor_pkg::ACCESS_CNT_W-1:0]   cnt_reg;

    // per-channel storage
    logic [3:0] chan_cfg_reg  [signaling_extractor_pkg::CHAN_COUNT];
    logic [3:0] sig_cur_reg   [signaling_extractor_pkg::CHAN_COUNT];
    logic [3:0] sig_h1_reg    [signaling_extractor_pkg::CHAN_COUNT];
    logic [3:0] sig_h2_reg    [signaling_extractor_pkg::CHAN_COUNT];
    logic [3:0] sig_vis_reg   [signaling_extractor_pkg::CHAN_COUNT];

    // pcm output stage
    logic       pcm_valid_reg;
    logic [7:0] pcm_data_reg;
    logic       sig_stream_reg;

    // decoded configuration
    logic       mode_esf;
    logic       mode_alt;
    logic       extract_off;
    logic       pch_en;
    logic       ia_enable;

    // bus decode
    logic       bus_req;
    logic       bus_wr;
    logic [7:0] bus_index;

    // stream decode
    logic       sig_frame;
    logic [1:0] sig_slot;
    logic       sf_end;
    logic [3:0] chan_cfg_now;
    logic [3:0] cur_merged;
    logic       launch;

    // which signaling bit a frame carries (3=A .. 0=D); valid flag in msb
    function automatic logic [2:0] sig_slot_of(input logic [4:0] frame, input logic esf);
        logic [2:0] r;
        r = 3'b000;
        if (frame == signaling_extractor_pkg::FRAME_A) begin
            r = {1'b1, 2'(signaling_extractor_pkg::BIT_A)};
        end else if (frame == signaling_extractor_pkg::FRAME_B) begin
            r = {1'b1, 2'(signaling_extractor_pkg::BIT_B)};
        end else if (esf && frame == signaling_extractor_pkg::FRAME_C) begin
            r = {1'b1, 2'(signaling_extractor_pkg::BIT_C)};
        end else if (esf && frame == signaling_extractor_pkg::FRAME_D) begin
            r = {1'b1, 2'(signaling_extractor_pkg::BIT_D)};
        end
        return r;
    endfunction

    // index of a channel inside a block of internal addresses
    function automatic logic [4:0] chan_of(input logic [5:0] addr, input logic [5:0] first);
        logic [5:0] d;
        d = addr - first;
        return d[4:0];
    endfunction

    // superframe formats repeat A and B in the C and D positions
    function automatic logic [3:0] sig_view(input logic [3:0] s, input logic esf);
        logic [3:0] r;
        r = s;
        if (!esf) begin
            r[signaling_extractor_pkg::BIT_C] = s[signaling_extractor_pkg::BIT_A]; // R18
            r[signaling_extractor_pkg::BIT_D] = s[signaling_extractor_pkg::BIT_B]; // R18
        end
        return r;
    endfunction

    assign mode_esf    = config_reg[signaling_extractor_pkg::CFG_ESF_BIT];            // R1
    assign mode_alt    = !mode_esf && config_reg[signaling_extractor_pkg::CFG_FMS_HI_BIT]; // R2
    assign extract_off = !mode_esf && config_reg[signaling_extractor_pkg::CFG_FMS_LO_BIT]; // R3
    assign pch_en      = config_reg[signaling_extractor_pkg::CFG_PCH_BIT];
    assign ia_enable   = config_reg[signaling_extractor_pkg::CFG_IA_BIT];

    assign bus_req   = cyc_i && stb_i && !ack_reg;
    assign bus_wr    = bus_req && we_i && sel_i[0];
    assign bus_index = adr_i[signaling_extractor_pkg::ADR_W-1:signaling_extractor_pkg::ADR_LSB];

    // the engine only runs in indirect mode, so a host that skipped the enable sees no busy
    assign launch = bus_wr && bus_index == signaling_extractor_pkg::REG_ADDR_CTRL
                    && ia_enable && eng_reg == signaling_extractor_pkg::ENG_IDLE; // R4 R10

    assign {sig_frame, sig_slot} = sig_slot_of(pcm_frame_i, mode_esf);
    assign sf_end = pcm_valid_i && !pcm_fbit_i && pcm_chan_i == signaling_extractor_pkg::LAST_CHAN
                    && pcm_frame_i == (mode_esf ? signaling_extractor_pkg::FRAME_D
                                                : signaling_extractor_pkg::FRAME_B);
    assign chan_cfg_now = (pcm_chan_i <= signaling_extractor_pkg::LAST_CHAN && pch_en)
                          ? chan_cfg_reg[pcm_chan_i] : 4'h0; // R5

    always_comb begin
        cur_merged = 4'h0;
        if (pcm_chan_i <= signaling_extractor_pkg::LAST_CHAN) begin
            cur_merged = sig_cur_reg[pcm_chan_i];
            cur_merged[sig_slot] = pcm_data_i[0];
        end
    end

    // wishbone answer: one wait state, ack dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (ce_i && bus_req) begin
            dat_reg <= 32'h0000_0000;
            case (bus_index)
                signaling_extractor_pkg::REG_CONFIG:    dat_reg[4:0] <= config_reg;
                signaling_extractor_pkg::REG_STATUS:
                    dat_reg[signaling_extractor_pkg::STATUS_BUSY_BIT] <= busy_reg; // R7
                signaling_extractor_pkg::REG_ADDR_CTRL: begin
                    dat_reg[signaling_extractor_pkg::DIR_BIT] <= direction_reg;
                    dat_reg[5:0] <= iaddr_reg;
                end
                signaling_extractor_pkg::REG_DATA_BUF:  dat_reg[3:0] <= nibble_reg;
                default:                                dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // extractor configuration: written directly or through internal address 20H
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_reg <= signaling_extractor_pkg::CFG_RESET; // R6
        end else if (ce_i) begin
            if (bus_wr && bus_index == signaling_extractor_pkg::REG_CONFIG) begin
                config_reg <= dat_i[signaling_extractor_pkg::CFG_W-1:0];
            end else if (eng_reg == signaling_extractor_pkg::ENG_DONE && !direction_reg
                         && iaddr_reg == signaling_extractor_pkg::EXT_CFG_ADDR) begin
                config_reg[3:0] <= nibble_reg; // R16
            end
        end
    end

    // address/control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            direction_reg <= 1'b0;
            iaddr_reg     <= signaling_extractor_pkg::IADDR_RESET;
        end else if (ce_i && bus_wr && bus_index == signaling_extractor_pkg::REG_ADDR_CTRL) begin
            direction_reg <= dat_i[signaling_extractor_pkg::DIR_BIT];                 // R11
            iaddr_reg     <= dat_i[signaling_extractor_pkg::IADDR_W-1:0];             // R11
        end
    end

    // indirect engine: busy for the whole access, work done in the last cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng_reg  <= signaling_extractor_pkg::ENG_IDLE;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else if (ce_i) begin
            case (eng_reg)
                signaling_extractor_pkg::ENG_IDLE: begin
                    if (launch) begin
                        eng_reg  <= signaling_extractor_pkg::ENG_WAIT; // R10
                        busy_reg <= 1'b1; // R7
                        cnt_reg  <= signaling_extractor_pkg::ACCESS_CNT_W'(
                                    signaling_extractor_pkg::ACCESS_CYCLES - 2);
                    end
                end
                signaling_extractor_pkg::ENG_WAIT: begin
                    if (cnt_reg == '0) begin
                        eng_reg <= signaling_extractor_pkg::ENG_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1; // R9
                    end
                end
                signaling_extractor_pkg::ENG_DONE: begin
                    eng_reg  <= signaling_extractor_pkg::ENG_IDLE;
                    busy_reg <= 1'b0; // R7 R9
                end
                default: begin
                    eng_reg  <= signaling_extractor_pkg::ENG_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // data buffer: host writes it, an indirect read overwrites it at completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nibble_reg <= signaling_extractor_pkg::NIBBLE_RESET;
        end else if (ce_i) begin
            if (eng_reg == signaling_extractor_pkg::ENG_DONE && direction_reg) begin
                if (!iaddr_reg[signaling_extractor_pkg::SPACE_BIT]) begin // R14
                    if (iaddr_reg >= signaling_extractor_pkg::SIG_FIRST
                        && iaddr_reg <= signaling_extractor_pkg::SIG_LAST) begin
                        nibble_reg <= sig_view(sig_vis_reg[chan_of(iaddr_reg,
                                      signaling_extractor_pkg::SIG_FIRST)], mode_esf); // R13 R15 R17
                    end else begin
                        nibble_reg <= 4'h0; // R16
                    end
                end else if (iaddr_reg == signaling_extractor_pkg::EXT_CFG_ADDR) begin
                    nibble_reg <= config_reg[3:0];
                end else if (iaddr_reg <= signaling_extractor_pkg::CCFG_LAST) begin
                    nibble_reg <= chan_cfg_reg[chan_of(iaddr_reg, signaling_extractor_pkg::CCFG_FIRST)];
                end else begin
                    nibble_reg <= 4'h0;
                end
            end else if (bus_wr && bus_index == signaling_extractor_pkg::REG_DATA_BUF) begin
                nibble_reg <= dat_i[signaling_extractor_pkg::NIBBLE_W-1:0]; // R12
            end
        end
    end

    // per-channel configuration, written only through the indirect engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < signaling_extractor_pkg::CHAN_COUNT; i++) begin
                chan_cfg_reg[i] <= 4'h0;
            end
        end else if (ce_i && eng_reg == signaling_extractor_pkg::ENG_DONE && !direction_reg
                     && iaddr_reg >= signaling_extractor_pkg::CCFG_FIRST
                     && iaddr_reg <= signaling_extractor_pkg::CCFG_LAST) begin
            chan_cfg_reg[chan_of(iaddr_reg, signaling_extractor_pkg::CCFG_FIRST)] <= nibble_reg; // R14 R16 R21
        end
    end

    // signaling under assembly for the current superframe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < signaling_extractor_pkg::CHAN_COUNT; i++) begin
                sig_cur_reg[i] <= 4'h0;
            end
        end else if (ce_i && pcm_valid_i && !pcm_fbit_i && sig_frame && !extract_off
                     && pcm_chan_i <= signaling_extractor_pkg::LAST_CHAN) begin
            sig_cur_reg[pcm_chan_i] <= cur_merged;
        end
    end

    // history: visible state lags the newest superframe by two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < signaling_extractor_pkg::CHAN_COUNT; i++) begin
                sig_h1_reg[i]  <= 4'h0;
                sig_h2_reg[i]  <= 4'h0;
                sig_vis_reg[i] <= 4'h0;
            end
        end else if (ce_i && sf_end && !extract_off) begin
            for (int i = 0; i < signaling_extractor_pkg::CHAN_COUNT; i++) begin
                // the last channel's final bit arrives in this same cycle
                sig_h1_reg[i] <= (5'(i) == pcm_chan_i && sig_frame) ? cur_merged : sig_cur_reg[i];
                sig_h2_reg[i] <= sig_h1_reg[i]; // R19
                if (!(pch_en && chan_cfg_reg[i][signaling_extractor_pkg::CC_DBN_BIT])
                    || sig_h1_reg[i] == sig_h2_reg[i]) begin // R5 R20
                    sig_vis_reg[i] <= sig_h2_reg[i]; // R19
                end
            end
        end
    end

    // pcm processing: invert, fix signaling bit, emit signaling stream
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcm_valid_reg  <= 1'b0;
            pcm_data_reg   <= 8'h00;
            sig_stream_reg <= 1'b0;
        end else if (ce_i) begin
            pcm_valid_reg  <= pcm_valid_i;
            pcm_data_reg   <= pcm_data_i;
            sig_stream_reg <= 1'b0;
            if (pcm_valid_i && !pcm_fbit_i) begin // R21
                if (chan_cfg_now[signaling_extractor_pkg::CC_FLP_BIT]) begin
                    pcm_data_reg <= ~pcm_data_i; // R5 R21
                end
                if (chan_cfg_now[signaling_extractor_pkg::CC_FIX_BIT] && !extract_off) begin // R3
                    pcm_data_reg[0] <= chan_cfg_now[signaling_extractor_pkg::CC_LVL_BIT]
                                       ^ chan_cfg_now[signaling_extractor_pkg::CC_FLP_BIT]; // R22
                end
                if (sig_frame && !extract_off) begin
                    sig_stream_reg <= pcm_data_i[0]; // R3
                end
            end
        end
    end

    assign dat_o        = dat_reg;
    assign ack_o        = ack_reg;
    assign pcm_valid_o  = pcm_valid_reg;
    assign pcm_data_o   = pcm_data_reg;
    assign sig_stream_o = sig_stream_reg;

    // the alt flag only shares the superframe path; kept for readability of the mode decode
    logic unused_mode;
    assign unused_mode = mode_alt;

endmodule // signaling_extractor

// ### dv/signaling_extractor_chk.sv
// port checker for the signaling extractor: bus handshake, reset state, pcm path
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
module signaling_extractor_chk (
    input wire logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [9:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic        pcm_valid_i, pcm_fbit_i, pcm_valid_o, sig_stream_o,
    input wire logic [4:0]  pcm_chan_i, pcm_frame_i,
    input wire logic [7:0]  pcm_data_i, pcm_data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s; cyc_i && stb_i && !ack_o && ce_i; endsequence
    sequence rd_s; req_s ##0 !we_i; endsequence
    logic sig_frame;
    assign sig_frame = pcm_frame_i inside {5'h06, 5'h0c, 5'h12, 5'h18};
    a_ack_after_req: assert property (req_s |=> ack_o) else $error("no ack after request");
    a_ack_one_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("ack held too long");
    a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_reset_quiet:
        assert property ($fell(rst_i) |-> !ack_o && dat_o == 32'h0 && !pcm_valid_o) else $error("not quiet after reset");
    a_valid_follows: assert property (ce_i |=> pcm_valid_o == $past(pcm_valid_i)) else $error("valid not delayed");
    a_fbit_unchanged:
        assert property (ce_i && pcm_valid_i && pcm_fbit_i |=> pcm_data_o == $past(pcm_data_i)) else $error("fbit altered");
    a_sig_frames_only:
        assert property (ce_i && pcm_valid_i && !sig_frame |=> !sig_stream_o) else $error("stray signaling bit");
    a_status_upper:
        assert property (rd_s ##0 adr_i[9:2] == 8'h41 |=> dat_o[31:8] == 24'h0 && dat_o[6:0] == 7'h0)
        else $error("status spare bits set");
    a_unmapped_zero:
        assert property (rd_s ##0 !(adr_i[9:2] inside {[8'h40:8'h43]}) |=> ack_o && dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // signaling_extractor_chk
bind signaling_extractor signaling_extractor_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .pcm_valid_i(pcm_valid_i), .pcm_fbit_i(pcm_fbit_i), .pcm_valid_o(pcm_valid_o), .sig_stream_o(sig_stream_o),
    .pcm_chan_i(pcm_chan_i), .pcm_frame_i(pcm_frame_i), .pcm_data_i(pcm_data_i), .pcm_data_o(pcm_data_o));

// ### dv/pcm_source.sv
// framer model: 12-frame superframes, each frame a framing byte then 24 channels
// assumes run_i rises after reset; signaling bits A,B of channel c are c[0],c[1]
`timescale 1ns/10ps
module pcm_source (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    output logic            valid_o,
    output logic            fbit_o,
    output logic      [4:0] chan_o,
    output logic      [4:0] frame_o,
    output logic      [7:0] data_o
);
    logic [4:0] pos_reg;
    logic [4:0] frame_reg;
    logic [4:0] c;
    assign c = pos_reg - 5'h01;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {valid_o, fbit_o, chan_o, pos_reg, data_o, frame_o} <= '0;
            frame_reg <= 5'h01;
        end else if (!run_i) begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
        end else begin
            valid_o <= 1'b1;
            fbit_o  <= pos_reg == 5'h00;
            chan_o  <= (pos_reg == 5'h00) ? 5'h00 : c;
            frame_o <= frame_reg;
            // framing byte keeps lsb low so the signaling stream never depends on it
            data_o  <= {data_o[6:0] ^ 7'h35, pos_reg != 5'h00 &&
                        (frame_reg == 5'h06 ? c[0] : frame_reg == 5'h0c ? c[1] : data_o[3])};
            pos_reg <= (pos_reg == 5'h18) ? 5'h00 : pos_reg + 5'h01;
            if (pos_reg == 5'h18) frame_reg <= (frame_reg == 5'h0c) ? 5'h01 : frame_reg + 5'h01;
        end
    end
endmodule // pcm_source

// ### dv/signaling_extractor_bench.sv
// bench for the signaling extractor: bus registers, indirect engine and pcm path
// assumes pcm_source as the framer and the bound port checker
`timescale 1ns/10ps
module signaling_extractor_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, run = 1'b0;
    logic        off = 1'b0, mon = 1'b0, dmon = 1'b0, cs = 1'b0, es = 1'b0, cd = 1'b0, e1;
    logic        ack_o, pv, pf, pcm_valid_o, sig_stream_o;
    logic [9:0]  adr_i = 10'h000;
    logic [3:0]  sel_i = 4'h0, v;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [4:0]  pc, pfr, tch = 5'h1f;
    logic [4:0]  cl [3] = '{5'h00, 5'h17, 5'h00};
    logic [7:0]  pd, pcm_data_o, ed;
    int          failures = 0, samples_checked = 0, seed = 56303, cyc_n = 0, t0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    signaling_extractor u_signaling_extractor (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pcm_valid_i(pv), .pcm_fbit_i(pf), .pcm_chan_i(pc), .pcm_frame_i(pfr), .pcm_data_i(pd),
        .pcm_valid_o(pcm_valid_o), .pcm_data_o(pcm_data_o), .sig_stream_o(sig_stream_o));
    pcm_source u_pcm_source (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .valid_o(pv), .fbit_o(pf),
        .chan_o(pc), .frame_o(pfr), .data_o(pd));
    function automatic logic [31:0] sig_exp(input logic [4:0] c);
        return {28'h0, c[0], c[1], c[0], c[1]};
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {a, 2'b00};
        dat_i <= d;
        sel_i <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        q = dat_o;
        chk("ack latency", 32'h2, 32'(n));
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic iac(input logic r, input logic [5:0] a, input logic [3:0] d);
        int n;
        n = 0;
        if (!r) wb(1'b1, 8'h43, {28'h0, d});
        wb(1'b1, 8'h42, {24'h0, r, 1'b0, a});
        t0 = cyc_n;
        wb(1'b0, 8'h41, 32'h0);
        chk("busy", 32'h80, q);
        do begin
            wb(1'b0, 8'h41, 32'h0);
            n++;
        end while (q !== 32'h0 && n < 40);
        chk("access time", 32'h1, {31'h0, cyc_n - t0 < 90});
        if (r) wb(1'b0, 8'h43, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // pcm output lands one edge after its input, so compare at the following negedge
    always @(negedge clk_i) begin
        if (cs && mon) chk("sig_stream_o", {31'h0, es}, {31'h0, sig_stream_o});
        if (cd && dmon) chk("pcm_data_o", {24'h0, ed}, {24'h0, pcm_data_o});
        cs = pv && pc != tch;
        es = !off && pv && !pf && (pfr == 5'h06 || pfr == 5'h0c) && pd[0];
        cd = pv && !pf && pc == tch;
        ed = {~pd[7:1], 1'b0};
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        run   <= 1'b1;
        for (int i = 8'h40; i <= 8'h44; i++) begin
            wb(1'b0, 8'(i), 32'h0);
            chk("reset value", 32'h0, q);
        end
        wb(1'b1, 8'h42, 32'h81);
        wb(1'b0, 8'h41, 32'h0);
        chk("busy without enable", 32'h0, q);
        wb(1'b0, 8'h42, 32'h0);
        chk("address control", 32'h81, q);
        $display("test reset_and_refusal done");
        repeat (4) begin
            v = 4'($random(seed)) | 4'h2;
            e1 = 1'($random(seed));
            mon = 1'b0;
            off = !e1 && v[2];
            wb(1'b1, 8'h40, {27'h0, e1, v});
            mon = 1'b1;
            wb(1'b0, 8'h40, 32'h0);
            chk("configuration", {27'h0, e1, v}, q);
            iac(1'b1, 6'h20, 4'h0);
            chk("config nibble", {28'h0, v}, q);
            repeat (300) @(posedge clk_i);
        end
        $display("test frame_modes done");
        mon = 1'b0;
        off = 1'b0;
        wb(1'b1, 8'h40, 32'h03);
        mon = 1'b1;
        tch = 5'h01 + 5'({$random(seed)} % 22);
        cl[2] = tch ^ 5'h01;
        iac(1'b0, 6'h21 + 6'(tch), 4'hf);
        iac(1'b1, 6'h21 + 6'(tch), 4'h0);
        chk("channel config", 32'hf, q);
        dmon = 1'b1;
        repeat (1300) @(posedge clk_i);
        dmon = 1'b0;
        iac(1'b0, 6'h19, 4'h5);
        iac(1'b1, 6'h19, 4'h0);
        chk("ignored address", 32'h0, q);
        foreach (cl[i]) begin
            iac(1'b1, 6'h01 + 6'(cl[i]), 4'h0);
            chk("signaling", sig_exp(cl[i]), q);
        end
        $display("test channel_paths done");
        tally_and_finish;
    end
endmodule // signaling_extractor_bench
